/* core/timer_ctl.sv */
// timer control slice: soft reset handshake, enable protection, interrupt enables
// assumes apb master on pclk; flag events come from the counting datapath
`default_nettype none
module timer_ctl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] flag_event,
    output logic timer_enable,
    output logic [15:0] period,
    output logic [7:0] debug_ctrl,
    output logic irq
);
    // ****************************************
    // bus decode
    // ****************************************
    logic wr;
    logic rd;
    logic hit;
    logic busy;
    logic prot_ok;
    logic sync_done;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign hit = (paddr == tmr_ctl_pkg::ctrl_off) || (paddr == tmr_ctl_pkg::dbg_off)
        || (paddr == tmr_ctl_pkg::ien_clr_off) || (paddr == tmr_ctl_pkg::ien_set_off)
        || (paddr == tmr_ctl_pkg::flag_off) || (paddr == tmr_ctl_pkg::sync_off)
        || (paddr == tmr_ctl_pkg::per_off);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ****************************************
    // soft reset sequencer
    // ****************************************
    tmr_ctl_pkg::soft_reset_state_e st_ff;
    tmr_ctl_pkg::soft_reset_state_e nxt_st;
    logic soft_reset_req;
    logic sw_clear;
    assign soft_reset_req = wr && (paddr == tmr_ctl_pkg::ctrl_off)
        && pwdata[tmr_ctl_pkg::soft_reset_trigger_bit];
    assign busy = (st_ff != tmr_ctl_pkg::st_idle);
    assign sw_clear = (st_ff == tmr_ctl_pkg::st_done);

    sync_delay #(.depth(tmr_ctl_pkg::sync_stages)) i_sync_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(st_ff == tmr_ctl_pkg::st_sync && !sync_done),
        .done(sync_done)
    );

    always_comb
    begin
        case (st_ff)
            tmr_ctl_pkg::st_idle: nxt_st = soft_reset_req ? tmr_ctl_pkg::st_sync : st_ff;
            tmr_ctl_pkg::st_sync: nxt_st = sync_done ? tmr_ctl_pkg::st_done : st_ff;
            tmr_ctl_pkg::st_done: nxt_st = tmr_ctl_pkg::st_idle;
            default: nxt_st = tmr_ctl_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= tmr_ctl_pkg::st_idle;
        else
            st_ff <= nxt_st;
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] dbg_ff;
    logic [7:0] nxt_dbg;
    logic [7:0] ien_ff;
    logic [7:0] nxt_ien;
    logic [7:0] flag_ff;
    logic [7:0] nxt_flag;
    logic [15:0] per_ff;
    logic [15:0] nxt_per;
    logic en;
    assign en = ctrl_ff[tmr_ctl_pkg::enable_bit];
    assign prot_ok = !en;

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_dbg = dbg_ff;
        nxt_ien = ien_ff;
        nxt_per = per_ff;
        nxt_flag = flag_ff;
        if (wr && !busy && !soft_reset_req)
        begin
            if (paddr == tmr_ctl_pkg::flag_off)
                nxt_flag = flag_ff & ~pwdata[7:0];
            if (paddr == tmr_ctl_pkg::ien_clr_off)
                nxt_ien = ien_ff & ~(pwdata[7:0] & tmr_ctl_pkg::ien_mask);
            if (paddr == tmr_ctl_pkg::ien_set_off)
                nxt_ien = ien_ff | (pwdata[7:0] & tmr_ctl_pkg::ien_mask);
            if (paddr == tmr_ctl_pkg::dbg_off)
                nxt_dbg = pwdata[7:0];
            if (paddr == tmr_ctl_pkg::ctrl_off)
            begin
                nxt_ctrl[tmr_ctl_pkg::enable_bit] = pwdata[tmr_ctl_pkg::enable_bit];
                if (prot_ok)
                    nxt_ctrl = (nxt_ctrl & ~tmr_ctl_pkg::ctrl_mask)
                        | (pwdata[7:0] & tmr_ctl_pkg::ctrl_mask);
            end
            if (paddr == tmr_ctl_pkg::per_off && prot_ok)
                nxt_per = pwdata[15:0];
        end
        nxt_flag = nxt_flag | flag_event;
        if (sw_clear)
        begin
            nxt_ctrl = tmr_ctl_pkg::ctrl_rst;
            nxt_ien = tmr_ctl_pkg::ien_rst;
            nxt_flag = tmr_ctl_pkg::ien_rst;
            nxt_per = tmr_ctl_pkg::per_rst;
        end
        else if (soft_reset_req)
        begin
            nxt_ctrl[tmr_ctl_pkg::enable_bit] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= tmr_ctl_pkg::ctrl_rst;
            dbg_ff <= tmr_ctl_pkg::dbg_rst;
            ien_ff <= tmr_ctl_pkg::ien_rst;
            flag_ff <= tmr_ctl_pkg::ien_rst;
            per_ff <= tmr_ctl_pkg::per_rst;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            dbg_ff <= nxt_dbg;
            ien_ff <= nxt_ien;
            flag_ff <= nxt_flag;
            per_ff <= nxt_per;
        end
    end

    // ****************************************
    // read data and outputs
    // ****************************************
    logic [31:0] nxt_rd;
    logic [31:0] rd_ff;
    logic irq_ff;
    always_comb
    begin
        nxt_rd = tmr_ctl_pkg::rd_zero;
        case (paddr)
            tmr_ctl_pkg::ctrl_off: nxt_rd[7:0] = ctrl_ff | {7'h00, busy};
            tmr_ctl_pkg::dbg_off: nxt_rd[7:0] = dbg_ff;
            tmr_ctl_pkg::ien_clr_off: nxt_rd[7:0] = ien_ff;
            tmr_ctl_pkg::ien_set_off: nxt_rd[7:0] = ien_ff;
            tmr_ctl_pkg::flag_off: nxt_rd[7:0] = flag_ff;
            tmr_ctl_pkg::sync_off: nxt_rd[0] = busy;
            tmr_ctl_pkg::per_off: nxt_rd[15:0] = per_ff;
            default: nxt_rd = tmr_ctl_pkg::rd_zero;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_ff <= tmr_ctl_pkg::rd_zero;
            irq_ff <= 1'b0;
        end
        else
        begin
            rd_ff <= (psel && !penable && !pwrite) ? nxt_rd : rd_ff;
            irq_ff <= |(nxt_flag & nxt_ien);
        end
    end

    assign prdata = rd_ff;
    assign irq = irq_ff;
    assign timer_enable = en;
    assign period = per_ff;
    assign debug_ctrl = dbg_ff;

    // ****************************************
    // checks: enable bits
    // ****************************************
    chk_clr_clears: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && !soft_reset_req && paddr == tmr_ctl_pkg::ien_clr_off
        |=> ((ien_ff & $past(pwdata[7:0]) & tmr_ctl_pkg::ien_mask) == 8'h00))
        else $error("enable clear failed");
    chk_chan1_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && paddr == tmr_ctl_pkg::ien_clr_off
        && pwdata[tmr_ctl_pkg::chan1_en_bit]
        |=> !ien_ff[tmr_ctl_pkg::chan1_en_bit])
        else $error("channel 1 enable not cleared");
    chk_chan0_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && paddr == tmr_ctl_pkg::ien_clr_off
        && pwdata[tmr_ctl_pkg::chan0_en_bit]
        |=> !ien_ff[tmr_ctl_pkg::chan0_en_bit])
        else $error("channel 0 enable not cleared");
    chk_error_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && paddr == tmr_ctl_pkg::ien_clr_off
        && pwdata[tmr_ctl_pkg::error_en_bit]
        |=> !ien_ff[tmr_ctl_pkg::error_en_bit])
        else $error("error enable not cleared");
    chk_overflow_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && paddr == tmr_ctl_pkg::ien_clr_off
        && pwdata[tmr_ctl_pkg::overflow_en_bit]
        |=> !ien_ff[tmr_ctl_pkg::overflow_en_bit])
        else $error("overflow enable not cleared");
    chk_clr_others: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && paddr == tmr_ctl_pkg::ien_clr_off
        |=> ((ien_ff | ($past(pwdata[7:0]) & tmr_ctl_pkg::ien_mask))
            == ($past(ien_ff) | ($past(pwdata[7:0]) & tmr_ctl_pkg::ien_mask))))
        else $error("clear touched other enables");
    chk_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == tmr_ctl_pkg::ien_clr_off && pwdata[7:0] == 8'h00 && !sw_clear
        |=> $stable(ien_ff))
        else $error("zero write changed enables");
    chk_set_visible: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !busy && !soft_reset_req && paddr == tmr_ctl_pkg::ien_set_off
        |=> ((ien_ff & $past(pwdata[7:0]) & tmr_ctl_pkg::ien_mask)
            == ($past(pwdata[7:0]) & tmr_ctl_pkg::ien_mask)))
        else $error("enable set failed");

    // ****************************************
    // checks: soft reset
    // ****************************************
    // busy lasts sync_stages plus two cycles
    chk_reset_busy: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset_req && !busy |=> busy [*5] ##1 !busy)
        else $error("busy timing wrong");
    chk_trig_enabled: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset_req && !busy && en |=> busy)
        else $error("trigger refused while enabled");
    chk_reset_disables: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset_req |=> !en)
        else $error("soft reset left timer enabled");
    chk_reset_wins: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset_req && !busy |=> $stable(per_ff) && $stable(dbg_ff))
        else $error("write beside soft reset taken");
    chk_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
        sw_clear |=> !busy && ien_ff == tmr_ctl_pkg::ien_rst && !en)
        else $error("reset did not complete");
    chk_reset_dbg: assert property (@(posedge pclk) disable iff (!presetn)
        sw_clear |=> $stable(dbg_ff))
        else $error("soft reset touched debug control");
    chk_period_reset: assert property (@(posedge pclk) disable iff (!presetn)
        sw_clear
        |=> per_ff == tmr_ctl_pkg::per_rst && ctrl_ff == tmr_ctl_pkg::ctrl_rst)
        else $error("soft reset left registers set");

    // ****************************************
    // checks: protection and read back
    // ****************************************
    chk_prot_hold: assert property (@(posedge pclk) disable iff (!presetn)
        wr && en && paddr == tmr_ctl_pkg::per_off && !sw_clear |=> $stable(per_ff))
        else $error("protected write accepted");
    chk_prot_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        wr && en && paddr == tmr_ctl_pkg::ctrl_off
        |=> $stable(ctrl_ff & tmr_ctl_pkg::ctrl_mask))
        else $error("protected control bits changed");
    chk_clr_reads: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == tmr_ctl_pkg::ien_clr_off |-> prdata == {24'h000000, $past(ien_ff)})
        else $error("clear register read wrong");
    chk_set_reads: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == tmr_ctl_pkg::ien_set_off |-> prdata == {24'h000000, $past(ien_ff)})
        else $error("set register read wrong");
    chk_sync_reads: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == tmr_ctl_pkg::sync_off |-> prdata[0] == $past(busy))
        else $error("sync status read wrong");
    chk_trig_reads: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == tmr_ctl_pkg::ctrl_off
        |-> prdata[tmr_ctl_pkg::soft_reset_trigger_bit] == $past(busy))
        else $error("trigger bit read wrong");

    // ****************************************
    // checks: interrupt
    // ****************************************
    chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        flag_event != 8'h00 && !sw_clear
        |=> (flag_ff & $past(flag_event)) == $past(flag_event))
        else $error("flag event lost");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(flag_ff & ien_ff))
        else $error("irq mismatch");
endmodule : timer_ctl
`default_nettype wire

/* pkg/tmr_ctl_pkg.sv */
// package for the timer control slice: register map, fields, reset values, timing
// assumes a 32-bit apb bus on pclk
`default_nettype none
package tmr_ctl_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] dbg_off = 12'h004;
    localparam logic [11:0] ien_clr_off = 12'h008;
    localparam logic [11:0] ien_set_off = 12'h00c;
    localparam logic [11:0] flag_off = 12'h010;
    localparam logic [11:0] sync_off = 12'h014;
    localparam logic [11:0] per_off = 12'h018;
    // ****************************************
    // fields
    // ****************************************
    localparam int soft_reset_trigger_bit = 0;
    localparam int enable_bit = 1;
    localparam int overflow_en_bit = 0;
    localparam int error_en_bit = 1;
    localparam int chan0_en_bit = 4;
    localparam int chan1_en_bit = 5;
    localparam int ien_w = 8;
    localparam logic [7:0] ien_mask = 8'h33;
    localparam logic [7:0] ien_rst = 8'h00;
    localparam logic [7:0] ctrl_mask = 8'hfc;
    localparam logic [7:0] ctrl_rst = 8'h00;
    localparam logic [7:0] dbg_rst = 8'h00;
    localparam logic [15:0] per_rst = 16'h0000;
    localparam logic [31:0] rd_zero = 32'h0000_0000;
    // ****************************************
    // synchroniser depth of the soft reset
    // ****************************************
    localparam int sync_stages = 3;
    typedef enum logic [2:0]
    {
        st_idle = 3'b001,
        st_sync = 3'b010,
        st_done = 3'b100
    } soft_reset_state_e;
endpackage : tmr_ctl_pkg
`default_nettype wire

/* core/sync_delay.sv */
// shift chain that stands in for the crossing into the counter domain
// assumes one clock, asynchronous active low reset
`default_nettype none
module sync_delay #(
    parameter int depth = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic done
);
    logic [depth-1:0] chain_ff;
    logic [depth-1:0] nxt_chain;

    always_comb
    begin
        nxt_chain = {chain_ff[depth-2:0], start};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chain_ff <= '0;
        else
            chain_ff <= nxt_chain;
    end

    assign done = chain_ff[depth-1];
endmodule : sync_delay
`default_nettype wire

/* bench/test_timer_reset_irq_enable_clear.sv */
// self-checking bench for the timer control slice, driven over apb
// assumes tmr_ctl_pkg and timer_ctl are compiled first; single 20 mhz clock
`default_nettype none
module test_timer_reset_irq_enable_clear;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] flag_event = 8'h00;
    logic timer_enable;
    logic [15:0] period;
    logic [7:0] debug_ctrl;
    logic irq;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 59254;
    int n;
    logic [31:0] rdat;
    logic rerr;
    logic [7:0] en_exp;
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] bits [4] = '{8'h20, 8'h10, 8'h02, 8'h01};

    always #25 pclk = ~pclk;

    timer_ctl i_timer_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flag_event(flag_event), .timer_enable(timer_enable),
        .period(period), .debug_ctrl(debug_ctrl), .irq(irq));

    // ****************************************
    // helpers
    // ****************************************
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    // one apb transfer; request held until pready seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp_reg(rdat, exp);
    endtask : rd_chk

    function automatic logic [31:0] after_clr(input logic [7:0] en, input logic [7:0] cl);
        return {24'h000000, en & ~cl & tmr_ctl_pkg::ien_mask};
    endfunction : after_clr

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(tmr_ctl_pkg::ien_clr_off, 32'h0000_0000);
        rd_chk(tmr_ctl_pkg::sync_off, 32'h0000_0000);
        en_exp = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($random(seed));
            c = (i == 0) ? 8'h00 : 8'($random(seed));
            apb(1'b1, tmr_ctl_pkg::ien_set_off, {24'h000000, v});
            en_exp = (en_exp | v) & tmr_ctl_pkg::ien_mask;
            apb(1'b1, tmr_ctl_pkg::ien_clr_off, {24'h000000, c});
            en_exp = 8'(after_clr(en_exp, c));
            rd_chk(tmr_ctl_pkg::ien_clr_off, {24'h000000, en_exp});
            rd_chk(tmr_ctl_pkg::ien_set_off, {24'h000000, en_exp});
        end
        foreach (bits[i])
        begin
            apb(1'b1, tmr_ctl_pkg::ien_set_off, 32'h0000_0033);
            apb(1'b1, tmr_ctl_pkg::ien_clr_off, {24'h000000, bits[i]});
            rd_chk(tmr_ctl_pkg::ien_set_off, after_clr(8'h33, bits[i]));
            apb(1'b1, tmr_ctl_pkg::ien_set_off, {24'h000000, bits[i]});
            @(posedge pclk);
            flag_event <= bits[i];
            @(posedge pclk);
            flag_event <= 8'h00;
            @(posedge pclk);
            #1 cmp_bit(irq, 1'b1);
            apb(1'b1, tmr_ctl_pkg::ien_clr_off, {24'h000000, bits[i]});
            @(posedge pclk);
            #1 cmp_bit(irq, 1'b0);
            apb(1'b1, tmr_ctl_pkg::flag_off, 32'h0000_00ff);
        end
        apb(1'b1, tmr_ctl_pkg::dbg_off, 32'h0000_00a5);
        apb(1'b1, tmr_ctl_pkg::per_off, 32'h0000_1234);
        apb(1'b1, tmr_ctl_pkg::ctrl_off, 32'h0000_0002);
        apb(1'b1, tmr_ctl_pkg::per_off, 32'h0000_5678);
        apb(1'b1, tmr_ctl_pkg::ctrl_off, 32'h0000_00f2);
        rd_chk(tmr_ctl_pkg::per_off, 32'h0000_1234);
        rd_chk(tmr_ctl_pkg::ctrl_off, 32'h0000_0002);
        cmp_reg({16'h0000, period}, 32'h0000_1234);
        apb(1'b1, tmr_ctl_pkg::ien_set_off, 32'h0000_0033);
        // soft reset while enabled, other bits set in the same access
        apb(1'b1, tmr_ctl_pkg::ctrl_off, 32'h0000_00ff);
        // refused while the reset is busy
        apb(1'b1, tmr_ctl_pkg::dbg_off, 32'h0000_005a);
        rd_chk(tmr_ctl_pkg::sync_off, 32'h0000_0001);
        cmp_bit(timer_enable, 1'b0);
        n = 0;
        do
        begin
            apb(1'b0, tmr_ctl_pkg::sync_off, 32'h0000_0000);
            n++;
        end
        while (rdat[0] !== 1'b0 && n < 20);
        cmp_bit(rdat[0], 1'b0);
        rd_chk(tmr_ctl_pkg::ctrl_off, 32'h0000_0000);
        rd_chk(tmr_ctl_pkg::per_off, 32'h0000_0000);
        rd_chk(tmr_ctl_pkg::ien_set_off, 32'h0000_0000);
        rd_chk(tmr_ctl_pkg::dbg_off, 32'h0000_00a5);
        cmp_reg({16'h0000, period}, 32'h0000_0000);
        cmp_reg({24'h000000, debug_ctrl}, 32'h0000_00a5);
        apb(1'b0, 12'h01c, 32'h0000_0000);
        cmp_bit(rerr, 1'b1);
        cmp_reg(rdat, 32'h0000_0000);
        // hardware reset in mid-run clears the debug register too
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cmp_reg({24'h000000, debug_ctrl}, 32'h0000_0000);
        rd_chk(tmr_ctl_pkg::dbg_off, 32'h0000_0000);
        rd_chk(tmr_ctl_pkg::sync_off, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : test_timer_reset_irq_enable_clear
`default_nettype wire
